// ==== design/dtr_top.sv ====
`timescale 1ns/1ps
module dtr_top #(
  parameter int SCAN_W    = 4,
  parameter int POST_W    = 16,
  parameter int LINK_IDLE = 16,
  parameter int TB_DIV    = 1
) (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic [dtr_pkg::N_AUX_IN-1:0]   aux_input_pin,
  output logic      [dtr_pkg::N_AUX_OUT-1:0]  aux_output_pin,
  input  wire logic                           counter_one_clock_source,
  input  wire logic                           counter_two_clock_source,
  input  wire dtr_pkg::dtr_link_t             link_in,
  output dtr_pkg::dtr_link_t                  link_out,
  output dtr_pkg::dtr_link_t                  link_oe,
  input  wire logic                           link_clk_in,
  output logic                                link_clk_out,
  output logic                                link_clk_oe,
  input  wire logic                           cfg_wr,
  input  wire dtr_pkg::dtr_cfg_t              cfg_in,
  input  wire logic                           pacer_tick,
  input  wire logic                           acq_arm,
  input  wire logic                           pretrig_mode,
  input  wire logic                           sw_start,
  input  wire logic [POST_W-1:0]              post_count,
  input  wire logic [SCAN_W-1:0]              scan_len,
  output logic                                conv_accept,
  output logic                                scan_begin_pulse,
  output logic                                scan_hold_strobe,
  output logic                                mux_switch_pulse,
  output logic                                acq_done,
  output logic                                acq_busy,
  output logic                                ext_tb_edge,
  output logic                                update_strobe,
  output logic                                waveform_start,
  output logic                                link_clk_alive
);

  initial begin
    if (SCAN_W < 1 || POST_W < 1 || LINK_IDLE < 2 || TB_DIV < 1) begin
      $error("dtr_top: parameter out of range");
    end
  end

  localparam int LW = $clog2(LINK_IDLE + 1);
  localparam int DW = $clog2(TB_DIV + 1);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // link line that stands for a sink, or low where none exists
  function automatic logic link_for_sink(input int k, input dtr_pkg::dtr_link_t l);
    logic v;
    v = 1'b0;
    case (k)
      dtr_pkg::SNK_CONV:  v = l.convert;
      dtr_pkg::SNK_START: v = l.acq_begin;
      dtr_pkg::SNK_STOP:  v = l.acq_end;
      dtr_pkg::SNK_UPD:   v = l.update;
      dtr_pkg::SNK_WAVE:  v = l.waveform;
      default:            v = 1'b0;
    endcase
    return v;
  endfunction : link_for_sink

  function automatic logic sink_level(input logic [2:0] sel, input int k,
                                      input logic [dtr_pkg::N_AUX_IN-1:0] a,
                                      input dtr_pkg::dtr_link_t l);
    logic v;
    v = 1'b0;
    if (sel == dtr_pkg::SEL_LINK) begin
      v = link_for_sink(k, l);
    end else if (sel < 3'(dtr_pkg::N_AUX_IN)) begin
      v = a[sel];
    end
    return v;
  endfunction : sink_level

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [dtr_pkg::N_AUX_IN-1:0] aux_meta_r;
  logic [dtr_pkg::N_AUX_IN-1:0] aux_sync_r;
  dtr_pkg::dtr_link_t           link_meta_r;
  dtr_pkg::dtr_link_t           link_sync_r;
  logic [1:0]                   ctr_meta_r;
  logic [1:0]                   ctr_sync_r;
  logic                         lclk_meta_r;
  logic                         lclk_sync_r;
  logic                         lclk_prev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      aux_meta_r  <= '0;
      aux_sync_r  <= '0;
      link_meta_r <= '0;
      link_sync_r <= '0;
      ctr_meta_r  <= '0;
      ctr_sync_r  <= '0;
      lclk_meta_r <= 1'b0;
      lclk_sync_r <= 1'b0;
      lclk_prev_r <= 1'b0;
    end else begin
      aux_meta_r  <= aux_input_pin;
      aux_sync_r  <= aux_meta_r;
      link_meta_r <= link_in;
      link_sync_r <= link_meta_r;
      ctr_meta_r  <= {counter_two_clock_source, counter_one_clock_source};
      ctr_sync_r  <= ctr_meta_r;
      lclk_meta_r <= link_clk_in;
      lclk_sync_r <= lclk_meta_r;
      lclk_prev_r <= lclk_sync_r;
    end
  end

  // ---------------------------------------------------------------
  // configuration
  // ---------------------------------------------------------------
  dtr_pkg::dtr_cfg_t cfg_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= dtr_pkg::CFG_RESET;
    end else if (cfg_wr) begin
      cfg_r <= cfg_in;
    end
  end

  // ---------------------------------------------------------------
  // sink routing and edge detection
  // ---------------------------------------------------------------
  logic [dtr_pkg::N_SINK-1:0] sink_lvl;
  logic [dtr_pkg::N_SINK-1:0] sink_prev_r;
  logic [dtr_pkg::N_SINK-1:0] sink_edge;

  // per-sink selection, polarity picks the active edge
  always_comb begin
    for (int k = 0; k < dtr_pkg::N_SINK; k++) begin
      sink_lvl[k] = sink_level(cfg_r.in_sel[k], k, aux_sync_r, link_sync_r) ^ cfg_r.in_pol[k];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sink_prev_r <= '0;
    end else begin
      sink_prev_r <= sink_lvl;
    end
  end

  assign sink_edge = sink_lvl & ~sink_prev_r;

  // ---------------------------------------------------------------
  // acquisition sequencer
  // ---------------------------------------------------------------
  dtr_pkg::dtr_state_t state_r;
  logic                running;
  logic                start_ev;
  logic                stop_ev;
  logic                conv_ev;
  logic                gate_act;
  logic                accept;
  logic                scan_last;
  logic                post_last;
  logic                in_scan_r;
  logic [SCAN_W-1:0]   conv_idx_r;
  logic [POST_W-1:0]   post_cnt_r;

  assign running  = (state_r == dtr_pkg::ST_PRE) || (state_r == dtr_pkg::ST_POST);
  assign start_ev = (state_r == dtr_pkg::ST_ARMED) && (sink_edge[dtr_pkg::SNK_START] || sw_start);
  // stop edge opens the post phase
  assign stop_ev  = (state_r == dtr_pkg::ST_PRE) && sink_edge[dtr_pkg::SNK_STOP];
  assign conv_ev  = sink_edge[dtr_pkg::SNK_CONV] || pacer_tick;
  assign gate_act = sink_lvl[dtr_pkg::SNK_GATE];
  // gate holds off new scans only
  assign accept   = running && conv_ev && (in_scan_r || !gate_act);
  assign scan_last = ((in_scan_r ? conv_idx_r : '0) + 1'b1) >= scan_len;
  // a post count of zero behaves as one
  assign post_last = (state_r == dtr_pkg::ST_POST) && ((post_cnt_r + 1'b1) >= post_count);

  // pretrigger runs until stop, then counts post samples
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= dtr_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        dtr_pkg::ST_IDLE: begin
          if (acq_arm) begin
            state_r <= dtr_pkg::ST_ARMED;
          end
        end
        dtr_pkg::ST_ARMED: begin
          if (start_ev) begin
            state_r <= pretrig_mode ? dtr_pkg::ST_PRE : dtr_pkg::ST_POST;
          end
        end
        dtr_pkg::ST_PRE: begin
          if (stop_ev) begin
            state_r <= dtr_pkg::ST_POST;
          end
        end
        dtr_pkg::ST_POST: begin
          if (accept && post_last) begin
            state_r <= dtr_pkg::ST_IDLE;
          end
        end
        default: state_r <= dtr_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_r != dtr_pkg::ST_POST) begin
      post_cnt_r <= '0;
    end else if (accept) begin
      post_cnt_r <= post_cnt_r + 1'b1;
    end
  end

  // hold drops when the final conversion starts
  always_ff @(posedge clk) begin
    if (rst || !running) begin
      in_scan_r  <= 1'b0;
      conv_idx_r <= '0;
    end else if (accept) begin
      in_scan_r  <= !scan_last;
      conv_idx_r <= scan_last ? '0 : (in_scan_r ? conv_idx_r + 1'b1 : SCAN_W'(1));
    end
  end

  // ---------------------------------------------------------------
  // strobes one clock period each, scan hold and busy levels, 8-period mux pulse
  // ---------------------------------------------------------------
  logic start_pulse_r;
  logic stop_pulse_r;

  // one 50 ns period per strobe; scan_hold_strobe and acq_busy are levels
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_accept      <= 1'b0;
      scan_begin_pulse <= 1'b0;
      scan_hold_strobe <= 1'b0;
      acq_done         <= 1'b0;
      start_pulse_r    <= 1'b0;
      stop_pulse_r     <= 1'b0;
      ext_tb_edge      <= 1'b0;
      update_strobe    <= 1'b0;
      waveform_start   <= 1'b0;
      acq_busy         <= 1'b0;
    end else begin
      conv_accept      <= accept;
      // scan begins with its first accepted conversion
      scan_begin_pulse <= accept && !in_scan_r;
      scan_hold_strobe <= accept ? !scan_last : in_scan_r;
      acq_done         <= (state_r == dtr_pkg::ST_POST) && accept && post_last;
      start_pulse_r    <= start_ev;
      stop_pulse_r     <= stop_ev;
      ext_tb_edge      <= sink_edge[dtr_pkg::SNK_EXT_TB];
      update_strobe    <= sink_edge[dtr_pkg::SNK_UPD];
      waveform_start   <= sink_edge[dtr_pkg::SNK_WAVE];
      acq_busy         <= state_r != dtr_pkg::ST_IDLE;
    end
  end

  dtr_pulse #(
    .DELAY (dtr_pkg::MUX_DELAY_CYC),
    .WIDTH (dtr_pkg::MUX_WIDTH_CYC)
  ) u_mux_pulse (
    .clk   (clk),
    .rst   (rst),
    .trig  (accept),
    .pulse (mux_switch_pulse)
  );

  // ---------------------------------------------------------------
  // output routing
  // ---------------------------------------------------------------
  logic [dtr_pkg::N_SRC-1:0] src_vec;

  always_comb begin
    src_vec                          = '0;
    src_vec[dtr_pkg::SRC_SCAN_BEGIN] = scan_begin_pulse;
    src_vec[dtr_pkg::SRC_SCAN_HOLD]  = scan_hold_strobe;
    src_vec[dtr_pkg::SRC_ACQ_DONE]   = acq_done;
    src_vec[dtr_pkg::SRC_CONVERT]    = conv_accept;
    src_vec[dtr_pkg::SRC_MUX_SWITCH] = mux_switch_pulse;
    src_vec[dtr_pkg::SRC_COUNTER_ONE_CLOCK_SOURCE]   = ctr_sync_r[0];
    src_vec[dtr_pkg::SRC_COUNTER_TWO_CLOCK_SOURCE]   = ctr_sync_r[1];
    src_vec[dtr_pkg::SRC_UPDATE]     = update_strobe;
    src_vec[dtr_pkg::SRC_START]      = start_pulse_r;
    src_vec[dtr_pkg::SRC_STOP]       = stop_pulse_r;
    src_vec[dtr_pkg::SRC_WAVE]       = waveform_start;
  end

  // any source to any output, polarity per pin
  always_ff @(posedge clk) begin
    if (rst) begin
      aux_output_pin <= '0;
    end else begin
      for (int i = 0; i < dtr_pkg::N_AUX_OUT; i++) begin
        aux_output_pin[i] <= ((cfg_r.out_sel[i] < 4'(dtr_pkg::N_SRC)) ? src_vec[cfg_r.out_sel[i]] : 1'b0)
                             ^ cfg_r.out_pol[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // sync link
  // ---------------------------------------------------------------
  // master drives the five strobes through the same flop stage
  always_ff @(posedge clk) begin
    if (rst) begin
      link_out <= '0;
      link_oe  <= '0;
    end else begin
      link_out.acq_begin <= start_pulse_r;
      link_out.acq_end   <= stop_pulse_r;
      link_out.convert   <= conv_accept;
      link_out.update    <= update_strobe;
      link_out.waveform  <= waveform_start;
      link_oe            <= cfg_r.master ? '1 : '0;
    end
  end

  logic [DW-1:0] div_r;

  // master derives the shared timebase from its own clock
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r        <= '0;
      link_clk_out <= 1'b0;
      link_clk_oe  <= 1'b0;
    end else begin
      link_clk_oe <= cfg_r.master;
      if (div_r >= DW'(TB_DIV - 1)) begin
        div_r        <= '0;
        link_clk_out <= ~link_clk_out;
      end else begin
        div_r <= div_r + 1'b1;
      end
    end
  end

  logic [LW-1:0] idle_r;

  // timebase watchdog: edges seen within LINK_IDLE cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      idle_r         <= LW'(LINK_IDLE);
      link_clk_alive <= 1'b0;
    end else begin
      if (lclk_sync_r != lclk_prev_r) begin
        idle_r <= '0;
      end else if (idle_r < LW'(LINK_IDLE)) begin
        idle_r <= idle_r + 1'b1;
      end
      link_clk_alive <= idle_r < LW'(LINK_IDLE);
    end
  end

endmodule : dtr_top

// ==== design/dtr_pkg.sv ====
package dtr_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ          = 20;
  localparam int STROBE_NS        = 50;
  localparam int MUX_DELAY_NS     = 50;
  localparam int MUX_WIDTH_NS     = 400;
  // least widths and delays both round up to whole periods
  localparam int STROBE_CYC       = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int MUX_DELAY_CYC    = (MUX_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int MUX_WIDTH_CYC    = (MUX_WIDTH_NS * CLK_MHZ + 999) / 1000;

  // ---------------------------------------------------------------
  // pin counts and sink/source codes
  // ---------------------------------------------------------------
  localparam int N_AUX_IN         = 6;
  localparam int N_AUX_OUT        = 3;
  localparam int N_SINK           = 7;
  localparam int N_SRC            = 11;

  localparam int SNK_CONV         = 0;
  localparam int SNK_EXT_TB       = 1;
  localparam int SNK_START        = 2;
  localparam int SNK_STOP         = 3;
  localparam int SNK_GATE         = 4;
  localparam int SNK_WAVE         = 5;
  localparam int SNK_UPD          = 6;

  localparam logic [2:0] SEL_LINK = 3'h6;
  localparam logic [2:0] SEL_NONE = 3'h7;

  localparam logic [3:0] SRC_SCAN_BEGIN = 4'h0;
  localparam logic [3:0] SRC_SCAN_HOLD  = 4'h1;
  localparam logic [3:0] SRC_ACQ_DONE   = 4'h2;
  localparam logic [3:0] SRC_CONVERT    = 4'h3;
  localparam logic [3:0] SRC_MUX_SWITCH = 4'h4;
  localparam logic [3:0] SRC_COUNTER_ONE_CLOCK_SOURCE   = 4'h5;
  localparam logic [3:0] SRC_COUNTER_TWO_CLOCK_SOURCE   = 4'h6;
  localparam logic [3:0] SRC_UPDATE     = 4'h7;
  localparam logic [3:0] SRC_START      = 4'h8;
  localparam logic [3:0] SRC_STOP       = 4'h9;
  localparam logic [3:0] SRC_WAVE       = 4'ha;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       waveform;
    logic       update;
    logic       convert;
    logic       acq_end;
    logic       acq_begin;
  } dtr_link_t;

  typedef struct packed {
    logic                          master;
    logic [N_SINK-1:0][2:0]        in_sel;
    logic [N_SINK-1:0]             in_pol;
    logic [N_AUX_OUT-1:0][3:0]     out_sel;
    logic [N_AUX_OUT-1:0]          out_pol;
  } dtr_cfg_t;

  // input slot per sink, index 6 down to 0: upd,wave,gate,stop,start,ext_tb,conv
  localparam dtr_cfg_t CFG_RESET = '{
    master:  1'b0,
    in_sel:  {3'h3, 3'h4, 3'h5, 3'h2, 3'h1, SEL_NONE, 3'h0},
    in_pol:  7'h00,
    out_sel: {SRC_MUX_SWITCH, SRC_CONVERT, SRC_UPDATE},
    out_pol: 3'h0
  };

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_PRE   = 4'b0100,
    ST_POST  = 4'b1000
  } dtr_state_t;

endpackage : dtr_pkg

// ==== design/dtr_pulse.sv ====
`timescale 1ns/1ps
module dtr_pulse #(
  parameter int DELAY = 1,
  parameter int WIDTH = 8
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic trig,
  output logic      pulse
);

  localparam int CW = $clog2(DELAY + WIDTH + 1);

  initial begin
    if (DELAY < 1 || WIDTH < 1) begin
      $error("dtr_pulse: delay and width must be at least one cycle");
    end
  end

  logic [CW-1:0] cnt_r;

  // a new trigger restarts the delay, then the pulse runs for WIDTH cycles
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (trig) begin
      cnt_r <= CW'(DELAY + WIDTH);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pulse <= 1'b0;
    end else begin
      pulse <= (cnt_r != '0) && (cnt_r <= CW'(WIDTH + 1)) && (cnt_r > CW'(1)) ||
               (cnt_r == CW'(1) && WIDTH == 1 && DELAY == 0);
    end
  end

endmodule : dtr_pulse

// ==== sim/dtr_checker.sv ====
`timescale 1ns/1ps
module dtr_checker (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic [dtr_pkg::N_AUX_OUT-1:0] aux_output_pin,
  input wire dtr_pkg::dtr_link_t            link_oe,
  input wire logic                          link_clk_out,
  input wire logic                          link_clk_oe,
  input wire logic                          conv_accept,
  input wire logic                          scan_begin_pulse,
  input wire logic                          scan_hold_strobe,
  input wire logic                          mux_switch_pulse,
  input wire logic                          acq_done,
  input wire logic                          acq_busy,
  input wire logic                          update_strobe
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  rst_clear_a: assert property (disable iff (1'b0) rst |=> aux_output_pin == '0 && link_oe == '0 && !acq_busy)
    else $error("outputs not cleared by reset");
  oe_follow_a: assert property (link_oe == {5{link_clk_oe}})
    else $error("link enables disagree with clock enable");
  clk_toggle_a: assert property (link_clk_oe && $past(link_clk_oe) |-> link_clk_out != $past(link_clk_out))
    else $error("master link clock not toggling");
  mux_width_a: assert property (conv_accept |=> mux_switch_pulse [*8] ##1 !mux_switch_pulse)
    else $error("mux pulse not 8 cycles after conversion");
  begin_conv_a: assert property (scan_begin_pulse |-> conv_accept)
    else $error("scan begin without conversion");
  hold_start_a: assert property ($rose(scan_hold_strobe) |-> scan_begin_pulse)
    else $error("scan hold rose outside scan start");
  hold_end_a: assert property ($fell(scan_hold_strobe) |-> conv_accept || !acq_busy)
    else $error("scan hold fell without final conversion");
  done_pulse_a: assert property (acq_done |-> conv_accept && acq_busy ##1 !acq_done && !acq_busy)
    else $error("done pulse malformed");
  idle_conv_a: assert property (!acq_busy |-> !conv_accept)
    else $error("conversion accepted while idle");
  strobe_one_a: assert property (update_strobe |=> !update_strobe)
    else $error("update strobe longer than one period");
endmodule : dtr_checker

// ==== sim/dtr_far_model.sv ====
`timescale 1ns/1ps
module dtr_far_model (
  input wire logic                         clk,
  input wire logic                         run_clk,
  output logic [dtr_pkg::N_AUX_IN-1:0]     aux_in,
  output dtr_pkg::dtr_link_t               link_in,
  output logic                             link_clk
);
  // ---------------------------------------------------------------
  // trigger sources and peer board
  // ---------------------------------------------------------------
  // peer stays quiet on the link except when pulse_link raises its start line
  initial begin
    aux_in  = '0;
    link_in = '0;
    link_clk = 1'b0;
    #13;
    // peer timebase, held low between bursts
    forever begin
      #200;
      link_clk = run_clk ? !link_clk : 1'b0;
    end
  end

  task set_pin(input int i, input logic v);
    @(negedge clk);
    aux_in[i] = v;
  endtask : set_pin

  task pulse_pin(input int i);
    set_pin(i, 1'b1);
    repeat (3) @(negedge clk);
    set_pin(i, 1'b0);
    repeat (4) @(negedge clk);
  endtask : pulse_pin

  // peer master raising its start line on the link
  task pulse_link();
    @(negedge clk);
    link_in.acq_begin = 1'b1;
    repeat (3) @(negedge clk);
    link_in.acq_begin = 1'b0;
    repeat (4) @(negedge clk);
  endtask : pulse_link
endmodule : dtr_far_model

// ==== sim/tb_daq_trigger_routing.sv ====
`timescale 1ns/1ps
module tb_daq_trigger_routing;
  logic               clk, rst, cfg_wr, pacer_tick, acq_arm, pretrig_mode, sw_start, run_lclk;
  logic [15:0]        post_count;
  logic [3:0]         scan_len;
  dtr_pkg::dtr_cfg_t  cfg;
  logic [5:0]         aux_in;
  logic [2:0]         aux_out;
  dtr_pkg::dtr_link_t far_link, link_w, link_out, link_oe;
  logic               lclk_in, lclk_out, lclk_oe, conv, sbeg, shold, mux, done, busy, upd, wave, alive;
  logic               ext, ctr1, ctr2;
  logic [10:0]        cur, prv;
  int                 n[11];
  int                 miscompares, compares, cyc;

  // ---------------------------------------------------------------
  // instances and wire resolution
  // ---------------------------------------------------------------
  assign link_w = (link_oe & link_out) | (~link_oe & far_link);
  assign cur = {ext, link_out.convert, aux_out, mux, wave, upd, done, sbeg, conv};

  dtr_far_model far (.clk(clk), .run_clk(run_lclk), .aux_in(aux_in), .link_in(far_link), .link_clk(lclk_in));

  dtr_top i_dut (.clk(clk), .rst(rst), .aux_input_pin(aux_in), .aux_output_pin(aux_out),
    .counter_one_clock_source(ctr1), .counter_two_clock_source(ctr2), .link_in(link_w),
    .link_out(link_out), .link_oe(link_oe), .link_clk_in(lclk_in), .link_clk_out(lclk_out),
    .link_clk_oe(lclk_oe), .cfg_wr(cfg_wr), .cfg_in(cfg), .pacer_tick(pacer_tick), .acq_arm(acq_arm),
    .pretrig_mode(pretrig_mode), .sw_start(sw_start), .post_count(post_count), .scan_len(scan_len),
    .conv_accept(conv), .scan_begin_pulse(sbeg), .scan_hold_strobe(shold), .mux_switch_pulse(mux),
    .acq_done(done), .acq_busy(busy), .ext_tb_edge(ext), .update_strobe(upd), .waveform_start(wave),
    .link_clk_alive(alive));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    prv <= cur;
    for (int i = 0; i < 11; i++) if (cur[i] && !prv[i]) n[i]++;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick

  task clr();
    foreach (n[i]) n[i] = 0;
  endtask : clr

  task arm();
    acq_arm = 1'b1;
    tick(1);
    acq_arm = 1'b0;
    tick(2);
  endtask : arm

  task sw();
    sw_start = 1'b1;
    tick(1);
    sw_start = 1'b0;
    tick(2);
  endtask : sw

  task ctick();
    pacer_tick = 1'b1;
    tick(1);
    pacer_tick = 1'b0;
    tick(11);
  endtask : ctick

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task s_dflt();
    clr();
    far.pulse_pin(3);
    far.pulse_pin(4);
    tick(4);
    check("link_oe", 16'(link_oe), 16'h0000);
    check("update", 16'(n[3]), 16'h0001);
    check("wave", 16'(n[4]), 16'h0001);
    check("out0", 16'(n[6]), 16'h0001);
  endtask : s_dflt

  task s_conv();
    scan_len = 4'h2;
    post_count = 16'h0003;
    clr();
    arm();
    ctick();
    check("armed conv", 16'(n[0]), 16'h0000);
    far.pulse_pin(1);
    repeat (3) ctick();
    check("convs", 16'(n[0]), 16'h0003);
    check("scans", 16'(n[1]), 16'h0002);
    check("done", 16'(n[2]), 16'h0001);
    check("mux", 16'(n[5]), 16'h0003);
    check("out1", 16'(n[7]), 16'h0003);
    check("out2", 16'(n[8]), 16'h0003);
    check("busy", 16'(busy), 16'h0000);
  endtask : s_conv

  task s_pre();
    pretrig_mode = 1'b1;
    scan_len = 4'h1;
    post_count = 16'h0002;
    clr();
    arm();
    sw();
    repeat (3) ctick();
    check("pre busy", 16'(busy), 16'h0001);
    check("pre done", 16'(n[2]), 16'h0000);
    far.pulse_pin(2);
    tick(4);
    repeat (2) ctick();
    check("pre convs", 16'(n[0]), 16'h0005);
    check("post done", 16'(n[2]), 16'h0001);
    pretrig_mode = 1'b0;
  endtask : s_pre

  task s_gate();
    post_count = 16'h0001;
    clr();
    arm();
    sw();
    far.set_pin(5, 1'b1);
    tick(5);
    ctick();
    check("gated", 16'(n[0]), 16'h0000);
    far.set_pin(5, 1'b0);
    tick(5);
    ctick();
    check("ungated", 16'(n[2]), 16'h0001);
  endtask : s_gate

  task s_lclk();
    run_lclk = 1'b1;
    tick(40);
    check("alive", 16'(alive), 16'h0001);
    run_lclk = 1'b0;
    tick(40);
    check("dead", 16'(alive), 16'h0000);
  endtask : s_lclk

  task load_cfg();
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(3);
  endtask : load_cfg

  task s_master();
    cfg = dtr_pkg::CFG_RESET;
    cfg.master = 1'b1;
    cfg.in_sel[dtr_pkg::SNK_EXT_TB] = 3'h5;
    cfg.out_sel[0] = dtr_pkg::SRC_START;
    cfg.out_sel[1] = dtr_pkg::SRC_COUNTER_ONE_CLOCK_SOURCE;
    cfg.out_pol[2] = 1'b1;
    load_cfg();
    check("master oe", 16'(link_oe), 16'h001f);
    check("out2 idle", 16'(aux_out[2]), 16'h0001);
    ctr1 = 1'b1;
    tick(4);
    check("ctr1 out", 16'(aux_out[1]), 16'h0001);
    ctr1 = 1'b0;
    clr();
    far.pulse_pin(5);
    check("ext tb", 16'(n[10]), 16'h0001);
    arm();
    sw();
    ctick();
    check("start out", 16'(n[6]), 16'h0001);
    check("link conv", 16'(n[9]), 16'h0001);
  endtask : s_master

  task s_link();
    cfg = dtr_pkg::CFG_RESET;
    cfg.in_sel[dtr_pkg::SNK_START] = dtr_pkg::SEL_LINK;
    cfg.out_sel[0] = dtr_pkg::SRC_STOP;
    cfg.out_sel[1] = dtr_pkg::SRC_COUNTER_TWO_CLOCK_SOURCE;
    load_cfg();
    ctr2 = 1'b1;
    tick(4);
    check("ctr2 out", 16'(aux_out[1]), 16'h0001);
    pretrig_mode = 1'b1;
    clr();
    arm();
    far.pulse_pin(1);
    ctick();
    check("pin start", 16'(n[0]), 16'h0000);
    far.pulse_link();
    far.pulse_pin(2);
    ctick();
    check("link start", 16'(n[2]), 16'h0001);
    check("stop out", 16'(n[6]), 16'h0001);
    pretrig_mode = 1'b0;
  endtask : s_link

  initial begin
    {rst, cfg_wr, pacer_tick, acq_arm, pretrig_mode, sw_start, run_lclk, ctr1, ctr2} = 9'h100;
    cfg = dtr_pkg::CFG_RESET;
    post_count = 16'h0001;
    scan_len = 4'h1;
    miscompares = 0;
    compares = 0;
    cyc = 0;
    tick(5);
    rst = 1'b0;
    tick(2);
    s_dflt();
    s_conv();
    s_pre();
    s_gate();
    s_lclk();
    s_master();
    s_link();
    give_verdict();
  end
endmodule : tb_daq_trigger_routing

bind dtr_top dtr_checker i_chk (.clk, .rst, .aux_output_pin, .link_oe, .link_clk_out, .link_clk_oe,
  .conv_accept, .scan_begin_pulse, .scan_hold_strobe, .mux_switch_pulse, .acq_done, .acq_busy, .update_strobe);
